/* File: hw/osc_cfg.svh */
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
`define OSC_CTRL_ADDR 8'hA9
`define OSC_BIT_EN 7
`define OSC_BIT_RDY 6
`define OSC_BIT_SUSP 5
`define OSC_BIT_SYNC 4
`define OSC_BIT_SSE 3
`define OSC_BIT_UNUSED 2
`define OSC_CTRL_RESET 8'hC0
`define OSC_CTRL_WMASK 8'hAB
`define OSC_SETTLE_NS 1000
`define OSC_SETTLE_CYC ((`OSC_SETTLE_NS + 99) / 100)
`define OSC_SYNC_TCLKS 3
`define OSC_SS_PERIOD 384
`define OSC_SS_STEP 32
`define OSC_SS_STEPS 12
`define OSC_SRC_INT 3'h0
`define OSC_SRC_EXT 3'h1
`define OSC_XMODE_OFF 3'h0
`define OSC_XMODE_XTAL_LO 3'h6
`endif

/* File: hw/osc_pkg.sv */
package osc_pkg;
  typedef enum logic [1:0] {
    OSC_OFF = 2'b00,
    OSC_SETTLE = 2'b01,
    OSC_RUN = 2'b10,
    OSC_SUSP = 2'b11
  } osc_state_e;
  typedef struct packed {
    logic en;
    logic susp;
    logic spread_spectrum_enable;
    logic [1:0] div;
  } osc_ctrl_s;
  typedef struct packed {
    logic a_oe;
    logic b_oe;
    logic a_is_osc;
    logic b_is_osc;
  } osc_pins_s;
endpackage

/* File: hw/osc_div.sv */
`timescale 1ns/10ps
`default_nettype none
module osc_div #(
  parameter int W = 3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic tick
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt_r <= '0;
    end else if (cnt_r >= limit) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end
  assign tick = run && (cnt_r >= limit);
endmodule
`default_nettype wire

/* File: hw/osc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
module osc_ctrl #(
  parameter int SETTLE = `OSC_SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic wake_event,
  input wire logic wake_from_timer,
  input wire logic timer_clk_pin,
  input wire logic [2:0] clock_source_select,
  input wire logic [2:0] ext_osc_mode,
  input wire logic ext_osc_clk_pin,
  output logic [7:0] sfr_rdata,
  output logic int_osc_running,
  output logic int_osc_freq_ready,
  output logic wake_timer_sync_busy,
  output logic sys_clock_net,
  output logic [3:0] dither_step,
  output logic crystal_pin_a_claim,
  output logic crystal_pin_b_claim
);
  typedef struct packed {
    osc_pkg::osc_ctrl_s ctl;
    osc_pkg::osc_state_e st;
    logic [7:0] settle;
    logic rdy;
    logic [1:0] sync_cnt;
    logic busy;
    logic [4:0] step_cnt;
    logic [3:0] tri_pos;
    logic tri_up;
    logic [3:0] dith;
    logic clk_out;
    logic [7:0] rdata;
    logic [2:0] tsync;
    logic [1:0] xsync;
    logic pa;
    logic pb;
  } osc_regs_s;
  osc_regs_s s_r;
  osc_regs_s s_nxt;
  logic osc_on;
  logic div_tick;
  logic [2:0] div_lim;
  logic tclk_rise;
  logic src_int;
  logic ctl_wr;
  assign ctl_wr = sfr_wr && (sfr_addr == `OSC_CTRL_ADDR);
  assign osc_on = (s_r.st == osc_pkg::OSC_SETTLE) || (s_r.st == osc_pkg::OSC_RUN);
  assign src_int = (clock_source_select == `OSC_SRC_INT);
  always_comb begin
    case (s_r.ctl.div)
      2'b00: div_lim = 3'h7;
      2'b01: div_lim = 3'h3;
      2'b10: div_lim = 3'h1;
      default: div_lim = 3'h0;
    endcase
  end
  osc_div #(.W(3)) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(osc_on),
    .limit(div_lim),
    .tick(div_tick)
  );
  assign tclk_rise = s_r.tsync[1] && !s_r.tsync[2];
  always_comb begin
    s_nxt = s_r;
    s_nxt.tsync = {s_r.tsync[1:0], timer_clk_pin};
    s_nxt.xsync = {s_r.xsync[0], ext_osc_clk_pin};
    if (ctl_wr) begin
      s_nxt.ctl.en = sfr_wdata[`OSC_BIT_EN];
      s_nxt.ctl.spread_spectrum_enable = sfr_wdata[`OSC_BIT_SSE];
      s_nxt.ctl.div = sfr_wdata[1:0];
      if (sfr_wdata[`OSC_BIT_SUSP]) begin
        s_nxt.ctl.susp = 1'b1;
      end
    end
    if (s_r.busy && tclk_rise) begin
      s_nxt.sync_cnt = s_r.sync_cnt + 2'h1;
      if (32'(s_r.sync_cnt) + 1 >= `OSC_SYNC_TCLKS) begin
        s_nxt.busy = 1'b0;
      end
    end
    case (s_r.st)
      osc_pkg::OSC_OFF: begin
        if (s_r.ctl.en) begin
          s_nxt.st = osc_pkg::OSC_SETTLE;
          s_nxt.settle = '0;
        end
      end
      osc_pkg::OSC_SETTLE: begin
        s_nxt.settle = s_r.settle + 8'h01;
        if (!s_r.ctl.en) begin
          s_nxt.st = osc_pkg::OSC_OFF;
        end else if (s_r.ctl.susp) begin
          s_nxt.st = osc_pkg::OSC_SUSP;
        end else if (32'(s_r.settle) + 1 >= SETTLE) begin
          s_nxt.st = osc_pkg::OSC_RUN;
        end
      end
      osc_pkg::OSC_RUN: begin
        if (!s_r.ctl.en) begin
          s_nxt.st = osc_pkg::OSC_OFF;
        end else if (s_r.ctl.susp) begin
          s_nxt.st = osc_pkg::OSC_SUSP;
        end
      end
      default: begin
        if (wake_event) begin
          s_nxt.ctl.susp = ctl_wr && sfr_wdata[`OSC_BIT_SUSP];
          s_nxt.st = osc_pkg::OSC_SETTLE;
          s_nxt.settle = '0;
          if (!wake_from_timer) begin
            s_nxt.busy = 1'b1;
            s_nxt.sync_cnt = '0;
          end
        end
      end
    endcase
    s_nxt.rdy = (s_r.st == osc_pkg::OSC_RUN) && s_r.ctl.en && !s_r.ctl.susp;
    if (osc_on && s_r.ctl.spread_spectrum_enable) begin
      if (s_r.step_cnt == 5'(`OSC_SS_STEP - 1)) begin
        s_nxt.step_cnt = '0;
        if (s_r.tri_up) begin
          s_nxt.tri_pos = s_r.tri_pos + 4'h1;
          if (32'(s_r.tri_pos) + 1 >= `OSC_SS_STEPS / 2) begin
            s_nxt.tri_up = 1'b0;
          end
        end else begin
          s_nxt.tri_pos = s_r.tri_pos - 4'h1;
          if (s_r.tri_pos == 4'h1) begin
            s_nxt.tri_up = 1'b1;
          end
        end
      end else begin
        s_nxt.step_cnt = s_r.step_cnt + 5'h01;
      end
      s_nxt.dith = s_r.tri_pos;
    end else begin
      s_nxt.step_cnt = '0;
      s_nxt.tri_pos = '0;
      s_nxt.tri_up = 1'b1;
      s_nxt.dith = '0;
    end
    if (src_int) begin
      s_nxt.clk_out = div_tick ? ~s_r.clk_out : s_r.clk_out;
    end else if (clock_source_select == `OSC_SRC_EXT) begin
      s_nxt.clk_out = s_r.xsync[1];
    end else begin
      s_nxt.clk_out = 1'b0;
    end
    s_nxt.pa = (ext_osc_mode >= `OSC_XMODE_XTAL_LO);
    s_nxt.pb = (ext_osc_mode != `OSC_XMODE_OFF);
    s_nxt.rdata = '0;
    if (sfr_rd && sfr_addr == `OSC_CTRL_ADDR) begin
      s_nxt.rdata[`OSC_BIT_EN] = s_r.ctl.en;
      s_nxt.rdata[`OSC_BIT_RDY] = s_r.rdy;
      s_nxt.rdata[`OSC_BIT_SUSP] = s_r.ctl.susp;
      s_nxt.rdata[`OSC_BIT_SYNC] = s_r.busy;
      s_nxt.rdata[`OSC_BIT_SSE] = s_r.ctl.spread_spectrum_enable;
      s_nxt.rdata[`OSC_BIT_UNUSED] = 1'b0;
      s_nxt.rdata[1:0] = s_r.ctl.div;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.ctl.en <= 1'b1;
      s_r.st <= osc_pkg::OSC_RUN;
      s_r.rdy <= 1'b1;
      s_r.tri_up <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign sfr_rdata = s_r.rdata;
  assign int_osc_running = s_r.rdy;
  assign int_osc_freq_ready = s_r.rdy;
  assign wake_timer_sync_busy = s_r.busy;
  assign sys_clock_net = s_r.clk_out;
  assign dither_step = s_r.dith;
  assign crystal_pin_a_claim = s_r.pa;
  assign crystal_pin_b_claim = s_r.pb;
  property p_rdy_clear;
    @(posedge sys_clk) disable iff (rst)
      (sfr_wr && sfr_addr == `OSC_CTRL_ADDR && !sfr_wdata[`OSC_BIT_EN]) |-> ##2 !s_r.rdy;
  endproperty
  a_rdy_clear: assert property (p_rdy_clear) else $error("ready not cleared");
  property p_susp_halts;
    @(posedge sys_clk) disable iff (rst)
      (s_r.st == osc_pkg::OSC_SUSP && src_int) |=> $stable(sys_clock_net);
  endproperty
  a_susp_halts: assert property (p_susp_halts) else $error("osc runs in suspend");
  property p_zero_bit;
    @(posedge sys_clk) disable iff (rst) sfr_rdata[`OSC_BIT_UNUSED] == 1'b0;
  endproperty
  a_zero_bit: assert property (p_zero_bit) else $error("bit 2 nonzero");
  property p_nodith;
    @(posedge sys_clk) disable iff (rst) !s_r.ctl.spread_spectrum_enable |=> dither_step == 4'h0;
  endproperty
  a_nodith: assert property (p_nodith) else $error("dither while off");
  property p_busy_set;
    @(posedge sys_clk) disable iff (rst)
      (s_r.st == osc_pkg::OSC_SUSP && wake_event && !wake_from_timer) |=> s_r.busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("sync busy not set");
  property p_pin_a;
    @(posedge sys_clk) disable iff (rst)
      (ext_osc_mode < `OSC_XMODE_XTAL_LO) |=> !crystal_pin_a_claim;
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a claimed");
  property p_step;
    @(posedge sys_clk) disable iff (rst)
      ($past(osc_on) && $past(s_r.ctl.spread_spectrum_enable) && $changed(s_r.tri_pos)) |->
        $past(s_r.step_cnt) == 5'h1F;
  endproperty
  a_step: assert property (p_step) else $error("dither step early");
  property p_div1;
    @(posedge sys_clk) disable iff (rst)
      (s_r.ctl.div == 2'b11 && osc_on && src_int) |-> div_tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one wrong");

  property p_rdy_rise;
    @(posedge sys_clk) disable iff (rst)
      $rose(int_osc_freq_ready) |-> $past(s_r.st, 2) == osc_pkg::OSC_SETTLE;
  endproperty
  a_rdy_rise: assert property (p_rdy_rise) else $error("ready set before settle");

  property p_pin_a_on;
    @(posedge sys_clk) disable iff (rst)
      (ext_osc_mode >= `OSC_XMODE_XTAL_LO) |=> crystal_pin_a_claim;
  endproperty
  a_pin_a_on: assert property (p_pin_a_on) else $error("pin a not claimed");

  property p_pin_b_on;
    @(posedge sys_clk) disable iff (rst)
      (ext_osc_mode != `OSC_XMODE_OFF) |=> crystal_pin_b_claim;
  endproperty
  a_pin_b_on: assert property (p_pin_b_on) else $error("pin b not claimed");

  property p_pin_b_off;
    @(posedge sys_clk) disable iff (rst)
      (ext_osc_mode == `OSC_XMODE_OFF) |=> !crystal_pin_b_claim;
  endproperty
  a_pin_b_off: assert property (p_pin_b_off) else $error("pin b claimed while off");

  property p_off_clk;
    @(posedge sys_clk) disable iff (rst)
      (s_r.st == osc_pkg::OSC_OFF && src_int) |=> $stable(sys_clock_net);
  endproperty
  a_off_clk: assert property (p_off_clk) else $error("clock runs while disabled");

  property p_en_start;
    @(posedge sys_clk) disable iff (rst)
      (s_r.st == osc_pkg::OSC_OFF && s_r.ctl.en) |=> s_r.st == osc_pkg::OSC_SETTLE;
  endproperty
  a_en_start: assert property (p_en_start) else $error("enable did not start osc");

  property p_tri_max;
    @(posedge sys_clk) disable iff (rst) dither_step <= 4'(`OSC_SS_STEPS / 2);
  endproperty
  a_tri_max: assert property (p_tri_max) else $error("dither beyond triangle peak");

  property p_ext_src;
    @(posedge sys_clk) disable iff (rst)
      (clock_source_select == `OSC_SRC_EXT) |=> sys_clock_net == $past(s_r.xsync[1]);
  endproperty
  a_ext_src: assert property (p_ext_src) else $error("external source not passed");

  property p_rsv_src;
    @(posedge sys_clk) disable iff (rst)
      (clock_source_select > `OSC_SRC_EXT) |=> !sys_clock_net;
  endproperty
  a_rsv_src: assert property (p_rsv_src) else $error("reserved source drives clock");

  property p_timer_wake;
    @(posedge sys_clk) disable iff (rst)
      (s_r.st == osc_pkg::OSC_SUSP && wake_event && wake_from_timer && !s_r.busy) |=>
        !s_r.busy;
  endproperty
  a_timer_wake: assert property (p_timer_wake) else $error("busy set on timer wake");

  property p_rd_rdy;
    @(posedge sys_clk) disable iff (rst)
      (sfr_rd && sfr_addr == `OSC_CTRL_ADDR) |=> sfr_rdata[`OSC_BIT_RDY] == $past(s_r.rdy);
  endproperty
  a_rd_rdy: assert property (p_rd_rdy) else $error("ready readback wrong");
endmodule
`default_nettype wire

/* File: bench/osc_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module osc_src_model #(
  parameter int EXT_HALF_NS = 70,
  parameter int TMR_HALF_NS = 300
) (
  output logic ext_clk,
  output logic timer_clk
);
  // pins left to the oscillator, no other driver
  initial begin
    ext_clk = 1'b0;
    timer_clk = 1'b0;
  end
  // cmos clock source on pin b
  always #(EXT_HALF_NS) ext_clk = ~ext_clk;
  // free running wake timer clock
  always #(TMR_HALF_NS) timer_clk = ~timer_clk;
endmodule
`default_nettype wire

/* File: bench/oscillator_control_and_pin_use_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module oscillator_control_and_pin_use_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic wake_event = 1'b0;
  logic wake_from_timer = 1'b0;
  logic [2:0] clock_source_select = 3'h0;
  logic [2:0] ext_osc_mode = 3'h0;
  logic timer_clk_pin, ext_osc_clk_pin, int_osc_running, int_osc_freq_ready;
  logic wake_timer_sync_busy, sys_clock_net, crystal_pin_a_claim, crystal_pin_b_claim;
  logic [7:0] sfr_rdata, rd_val;
  logic [3:0] dither_step;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int toggles;
  int model;
  integer seed = 32'h4cfc_cc8e;
  always #50 sys_clk = ~sys_clk;
  osc_ctrl #(.SETTLE(2)) u_dut (.sys_clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .wake_event, .wake_from_timer, .timer_clk_pin, .clock_source_select,
    .ext_osc_mode, .ext_osc_clk_pin, .sfr_rdata, .int_osc_running,
    .int_osc_freq_ready, .wake_timer_sync_busy, .sys_clock_net, .dither_step,
    .crystal_pin_a_claim, .crystal_pin_b_claim);
  osc_src_model u_src (.ext_clk(ext_osc_clk_pin), .timer_clk(timer_clk_pin));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    rd_val = sfr_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic count_tog(input int n);
    logic p;
    toggles = 0;
    p = sys_clock_net;
    repeat (n) begin
      @(negedge sys_clk);
      if (sys_clock_net !== p) toggles++;
      p = sys_clock_net;
    end
  endtask
  initial begin
    idle(6);
    rst = 1'b0;
    idle(2);
    rd(8'hA9);
    chk8("reset ctrl", 8'hC0, rd_val);
    rd(8'h55);
    chk8("unmapped", 8'h00, rd_val);
    for (int i = 0; i < 4; i++) begin
      wr(8'hA9, 8'h84 | i[7:0]);
      rd(8'hA9);
      chk8("ctrl div", 8'hC0 | i[7:0], rd_val);
      idle(40);
      count_tog(64);
      chk8("clk toggles", 8'(8 << i), 8'(toggles));
      chk8("dither off", 8'h00, {4'h0, dither_step});
    end
    for (int i = 0; i < 4; i++) begin
      model = ($random(seed) | 32'h80) & 32'hDF;
      wr(8'hA9, model[7:0]);
      rd(8'hA9);
      chk8("ctrl rand", (model[7:0] & 8'hAB) | 8'h40, rd_val);
    end
    wr(8'hA9, 8'h88);
    rd_val = {4'h0, dither_step};
    repeat (40) if ({4'h0, dither_step} === rd_val) @(negedge sys_clk);
    rd_val = {4'h0, dither_step};
    idle(31);
    chk8("dither hold", rd_val, {4'h0, dither_step});
    idle(1);
    chk1("dither step", 1'b1, dither_step !== rd_val[3:0]);
    wr(8'hA9, 8'h00);
    idle(2);
    chk1("ready off", 1'b0, int_osc_freq_ready);
    chk1("running off", 1'b0, int_osc_running);
    wr(8'hA9, 8'h80);
    chk1("ready settling", 1'b0, int_osc_freq_ready);
    idle(6);
    chk1("ready on", 1'b1, int_osc_freq_ready);
    wr(8'hA9, 8'hA0);
    idle(2);
    chk1("ready susp", 1'b0, int_osc_freq_ready);
    wake_event = 1'b1;
    @(negedge sys_clk);
    wake_event = 1'b0;
    idle(2);
    chk1("sync busy", 1'b1, wake_timer_sync_busy);
    idle(60);
    rd(8'hA9);
    chk8("after wake", 8'hC0, rd_val);
    for (int m = 0; m < 8; m++) begin
      ext_osc_mode = m[2:0];
      idle(3);
      chk1("pin a", m >= 6, crystal_pin_a_claim);
      chk1("pin b", m != 0, crystal_pin_b_claim);
    end
    ext_osc_mode = 3'h2;
    clock_source_select = 3'h1;
    idle(20);
    count_tog(64);
    chk1("ext clk runs", 1'b1, toggles > 0);
    clock_source_select = 3'h2;
    idle(3);
    chk1("reserved src", 1'b0, sys_clock_net);
    wr(8'hA9, 8'hA0);
    idle(2);
    wake_from_timer = 1'b1;
    wake_event = 1'b1;
    idle(1);
    wake_event = 1'b0;
    wake_from_timer = 1'b0;
    idle(2);
    chk1("timer wake busy", 1'b0, wake_timer_sync_busy);
    idle(8);
    chk1("ready timer wake", 1'b1, int_osc_freq_ready);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    idle(2);
    rd(8'hA9);
    chk8("reset again", 8'hC0, rd_val);
    tally_and_finish();
  end
endmodule
`default_nettype wire
